/* File: design/deac_store.sv */
// Device end: register set, unlock checker, write timer and byte array.
`timescale 1ns/1ps
`include "deac_cfg.svh"

// Functional notes
// R1: 256 bytes addressed by 8-bit address.
// R2: Array reached only through the registers.
// R3: Reads and writes allowed in normal operation.
// R4: Unlock port stores nothing, feeds checker.
// R5: Data register is 8-bit read/write.
// R6: Each write erases then programs the byte.
// R7: Internal timer sets write duration.
// R8: Protected array reads zero to programmer.
// R9: Core loads address, then sets read.
// R10: Read data lands next cycle.
// R11: Data register holds until read or write.
// R12: Core loads address and data before write.
// R13: 55h, AAh, then strobe starts write.
// R14: Wrong cycle spacing refuses the write.
// R15: Firmware should mask interrupts during unlock.
// R16: Strobe needs permit bit already set.
// R17: Permit bit changed only by core.
// R18: Clearing permit never aborts a write.
// R19: Firmware keeps permit clear normally.
// R20: Completion clears strobe, sets done flag.
// R21: Done flag sticks until software clears.
// R22: Busy strobe reads one, no restart.
// R23: Reset clears data, address, permit, strobes.
module deac_store (
  input  wire logic   clk,
  input  wire logic   reset,
  input  wire logic   clk_en,
  deac_if.device      bus,
  input  wire logic   code_protect,
  input  wire logic   prog_rd,
  input  wire logic [7:0] prog_addr,
  output logic [7:0]  prog_rdata,
  output logic        write_busy
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0]            mem [0:255];               // [R1] [R2]
  logic [7:0]            data_reg;
  logic [7:0]            addr_reg;
  logic                  permit_reg;
  logic                  refused_reg;
  logic                  done_reg;
  logic [7:0]            latch_addr_reg;
  logic [7:0]            latch_data_reg;
  logic [15:0]           timer_reg;
  logic [3:0]            gap_reg;
  deac_pkg::deac_wstate_t wstate_reg;
  deac_pkg::deac_kstate_t kstate_reg;

  logic wr_data, wr_addr, wr_ctrl, wr_key, start_write, busy;

  // Decode of core writes per register select.
  assign wr_data = bus.wr_en && bus.sel == `DEAC_SEL_DATA;
  assign wr_addr = bus.wr_en && bus.sel == `DEAC_SEL_ADDR;
  assign wr_ctrl = bus.wr_en && bus.sel == `DEAC_SEL_CTRL;
  assign wr_key  = bus.wr_en && bus.sel == `DEAC_SEL_KEY;  // [R4]
  assign busy    = wstate_reg != deac_pkg::DEAC_IDLE;
  assign write_busy = busy;

  // A write starts only when armed, permitted, idle and on the exact cycle.
  assign start_write = wr_ctrl && bus.wdata[`DEAC_CTRL_WR_BIT] && permit_reg  // [R16]
                       && kstate_reg == deac_pkg::DEAC_KEY_TWO                  // [R13]
                       && gap_reg == `DEAC_STROBE_GAP && !busy;                 // [R14] [R22]

  // --------------------------------------------------------------------------
  // Unlock sequence checker
  // --------------------------------------------------------------------------
  // Counts cycles since the last key step; any stray timing disarms it.
  always_ff @(posedge clk) begin
    if (reset) begin
      kstate_reg <= deac_pkg::DEAC_KEY_NONE;
      gap_reg    <= 4'h0;
    end else if (clk_en) begin
      if (gap_reg != 4'hF) begin
        gap_reg <= gap_reg + 4'h1;
      end
      case (kstate_reg)
        deac_pkg::DEAC_KEY_NONE: begin
          if (wr_key && bus.wdata == `DEAC_KEY_FIRST) begin
            kstate_reg <= deac_pkg::DEAC_KEY_ONE;
            gap_reg    <= 4'h1;
          end
        end
        deac_pkg::DEAC_KEY_ONE: begin
          if (wr_key && bus.wdata == `DEAC_KEY_SECOND && gap_reg == `DEAC_KEY_GAP) begin
            kstate_reg <= deac_pkg::DEAC_KEY_TWO;               // [R13] [R14]
            gap_reg    <= 4'h1;
          end else if (bus.wr_en || gap_reg > `DEAC_KEY_GAP) begin
            kstate_reg <= deac_pkg::DEAC_KEY_NONE;              // [R14]
          end
        end
        deac_pkg::DEAC_KEY_TWO: begin
          if (bus.wr_en || gap_reg > `DEAC_STROBE_GAP) begin
            kstate_reg <= deac_pkg::DEAC_KEY_NONE;              // [R13]
          end
        end
        default: kstate_reg <= deac_pkg::DEAC_KEY_NONE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Address, permit and refusal flag
  // --------------------------------------------------------------------------
  // Permit changes only on a core control write; hardware never clears it.
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_reg    <= `DEAC_ADDR_RESET;                          // [R23]
      permit_reg  <= 1'b0;                                      // [R23]
      refused_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_addr) begin
        addr_reg <= bus.wdata;                                  // [R1]
      end
      if (wr_ctrl) begin
        permit_reg  <= bus.wdata[`DEAC_CTRL_PERMIT_BIT];        // [R17]
        refused_reg <= bus.wdata[`DEAC_CTRL_WR_BIT] && !start_write && !busy;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Data register
  // --------------------------------------------------------------------------
  // A read strobe loads the array byte, a data write loads the written byte; otherwise the value is held.
  always_ff @(posedge clk) begin
    if (reset) begin
      data_reg <= `DEAC_DATA_RESET;                             // [R23]
    end else if (clk_en) begin
      if (wr_ctrl && bus.wdata[`DEAC_CTRL_RD_BIT]) begin
        data_reg <= mem[addr_reg];                              // [R9] [R10]
      end else if (wr_data) begin
        data_reg <= bus.wdata;                                  // [R5] [R11]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Write timer: erase phase then program phase
  // --------------------------------------------------------------------------
  // Address and data are latched at start, so later register or permit
  // changes cannot disturb a cycle already running.
  always_ff @(posedge clk) begin
    if (reset) begin
      wstate_reg     <= deac_pkg::DEAC_IDLE;                    // [R23]
      timer_reg      <= 16'h0000;
      latch_addr_reg <= 8'h00;
      latch_data_reg <= 8'h00;
    end else if (clk_en) begin
      case (wstate_reg)
        deac_pkg::DEAC_IDLE: begin
          if (start_write) begin
            wstate_reg     <= deac_pkg::DEAC_ERASE;             // [R3] [R6]
            timer_reg      <= 16'(`DEAC_ERASE_CYCLES - 1);       // [R7]
            latch_addr_reg <= addr_reg;
            latch_data_reg <= data_reg;
          end
        end
        deac_pkg::DEAC_ERASE: begin
          if (timer_reg == 16'h0000) begin
            wstate_reg <= deac_pkg::DEAC_PROGRAM;               // [R6]
            timer_reg  <= 16'(`DEAC_WRITE_CYCLES - `DEAC_ERASE_CYCLES - 1);
          end else begin
            timer_reg <= timer_reg - 16'h0001;                  // [R18]
          end
        end
        deac_pkg::DEAC_PROGRAM: begin
          if (timer_reg == 16'h0000) begin
            wstate_reg <= deac_pkg::DEAC_IDLE;                  // [R20]
          end else begin
            timer_reg <= timer_reg - 16'h0001;                  // [R7]
          end
        end
        default: wstate_reg <= deac_pkg::DEAC_IDLE;
      endcase
    end
  end

  // Array update: erased at erase end, programmed at program end.
  always_ff @(posedge clk) begin
    if (clk_en && timer_reg == 16'h0000) begin
      if (wstate_reg == deac_pkg::DEAC_ERASE) begin
        mem[latch_addr_reg] <= `DEAC_ERASED_BYTE;               // [R6]
      end else if (wstate_reg == deac_pkg::DEAC_PROGRAM) begin
        mem[latch_addr_reg] <= latch_data_reg;                  // [R6]
      end
    end
  end

  // --------------------------------------------------------------------------
  // Completion flag
  // --------------------------------------------------------------------------
  // Completion wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge clk) begin
    if (reset) begin
      done_reg <= 1'b0;
    end else if (clk_en) begin
      if (wstate_reg == deac_pkg::DEAC_PROGRAM && timer_reg == 16'h0000) begin
        done_reg <= 1'b1;                                       // [R20] [R21]
      end else if (bus.done_clr) begin
        done_reg <= 1'b0;                                       // [R21]
      end
    end
  end
  assign bus.done_flag = done_reg;

  // --------------------------------------------------------------------------
  // Read mux and programmer port
  // --------------------------------------------------------------------------
  // Read strobe bit always reads zero; write strobe reads one while busy.
  always_comb begin
    case (bus.sel)
      `DEAC_SEL_DATA: bus.rdata = data_reg;
      `DEAC_SEL_ADDR: bus.rdata = addr_reg;
      `DEAC_SEL_CTRL: bus.rdata = {4'h0, refused_reg, permit_reg, busy, 1'b0};  // [R22]
      default:        bus.rdata = 8'h00;                        // [R4]
    endcase
  end

  // Programmer sees zeroes while the array is protected; core is unaffected.
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_rdata <= 8'h00;
    end else if (clk_en && prog_rd) begin
      prog_rdata <= code_protect ? 8'h00 : mem[prog_addr];      // [R8]
    end
  end

endmodule

/* File: design/deac_cfg.svh */
// Constants for the data nonvolatile byte store controller.
`ifndef DEAC_CFG_SVH
`define DEAC_CFG_SVH

// --------------------------------------------------------------------------
// Register port selects and control bit positions
// --------------------------------------------------------------------------
`define DEAC_SEL_DATA        2'h0
`define DEAC_SEL_ADDR        2'h1
`define DEAC_SEL_CTRL        2'h2
`define DEAC_SEL_KEY         2'h3
`define DEAC_CTRL_RD_BIT     0
`define DEAC_CTRL_WR_BIT     1
`define DEAC_CTRL_PERMIT_BIT 2
`define DEAC_CTRL_ERR_BIT    3

// --------------------------------------------------------------------------
// Reset values, keys and timing
// --------------------------------------------------------------------------
`define DEAC_DATA_RESET      8'h00
`define DEAC_ADDR_RESET      8'h00
`define DEAC_KEY_FIRST       8'h55
`define DEAC_KEY_SECOND      8'hAA
`define DEAC_ERASED_BYTE     8'hFF
// Cycles allowed between first key write and second, and second and strobe.
`define DEAC_KEY_GAP         4'h2
`define DEAC_STROBE_GAP      4'h2
// Write time in microseconds and cycles at a 40 ns clock period.
`define DEAC_WRITE_TIME_US   5
`define DEAC_CLK_PERIOD_NS   40
`define DEAC_WRITE_CYCLES    ((`DEAC_WRITE_TIME_US * 1000) / `DEAC_CLK_PERIOD_NS)
`define DEAC_ERASE_CYCLES    (`DEAC_WRITE_CYCLES / 2)

`endif

/* File: design/deac_pkg.sv */
// Types used by the device end of the nonvolatile byte store controller.
package deac_pkg;

  typedef enum logic [1:0] {
    DEAC_IDLE    = 2'b00,
    DEAC_ERASE   = 2'b01,
    DEAC_PROGRAM = 2'b10
  } deac_wstate_t;

  typedef enum logic [1:0] {
    DEAC_KEY_NONE = 2'b00,
    DEAC_KEY_ONE  = 2'b01,
    DEAC_KEY_TWO  = 2'b10
  } deac_kstate_t;

endpackage

/* File: design/deac_if.sv */
// Register-file link between the core end and the store controller.
`timescale 1ns/1ps
interface deac_if;
  logic       wr_en;
  logic       rd_en;
  logic [1:0] sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       done_flag;
  logic       done_clr;

  modport device (
    input  wr_en,
    input  rd_en,
    input  sel,
    input  wdata,
    output rdata,
    output done_flag,
    input  done_clr
  );

  modport core (
    output wr_en,
    output rd_en,
    output sel,
    output wdata,
    input  rdata,
    input  done_flag,
    output done_clr
  );
endinterface

/* File: design/deac_core.sv */
// Core end: runs firmware-like read and unlocked write sequences.
`timescale 1ns/1ps
`include "deac_cfg.svh"

module deac_core (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  deac_if.core            bus,
  input  wire logic       req_read,
  input  wire logic       req_write,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            wr_done
);

  typedef enum logic [3:0] {
    DEAC_C_IDLE   = 4'b0000,
    DEAC_C_RADDR  = 4'b0001,
    DEAC_C_RSTRB  = 4'b0010,
    DEAC_C_RGET   = 4'b0011,
    DEAC_C_WADDR  = 4'b0100,
    DEAC_C_WDATA  = 4'b0101,
    DEAC_C_PERMIT = 4'b0110,
    DEAC_C_KEY1   = 4'b0111,
    DEAC_C_KEY2   = 4'b1000,
    DEAC_C_STROBE = 4'b1001,
    DEAC_C_WAIT   = 4'b1010,
    DEAC_C_CLOSE  = 4'b1011,
    DEAC_C_GAP1   = 4'b1100,
    DEAC_C_GAP2   = 4'b1101
  } deac_cstate_t;

  deac_cstate_t state_reg;
  logic [7:0]   addr_reg;
  logic [7:0]   data_reg;

  assign req_ready = state_reg == DEAC_C_IDLE;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  // Keys and strobe follow a fixed two-cycle spacing so the device cycle check
  // passes; nothing else can interleave, which stands in for masking interrupts.
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= DEAC_C_IDLE;
      addr_reg  <= 8'h00;
      data_reg  <= 8'h00;
      rd_data   <= 8'h00;
      rd_valid  <= 1'b0;
      wr_done   <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      wr_done  <= 1'b0;
      case (state_reg)
        DEAC_C_IDLE: begin
          addr_reg <= req_addr;
          data_reg <= req_data;
          if (req_write) begin
            state_reg <= DEAC_C_WADDR;
          end else if (req_read) begin
            state_reg <= DEAC_C_RADDR;
          end
        end
        DEAC_C_RADDR:  state_reg <= DEAC_C_RSTRB;   // [R9]
        DEAC_C_RSTRB:  state_reg <= DEAC_C_RGET;
        DEAC_C_RGET: begin
          rd_data   <= bus.rdata;
          rd_valid  <= 1'b1;
          state_reg <= DEAC_C_IDLE;
        end
        DEAC_C_WADDR:  state_reg <= DEAC_C_WDATA;   // [R12]
        DEAC_C_WDATA:  state_reg <= DEAC_C_PERMIT;
        DEAC_C_PERMIT: state_reg <= DEAC_C_KEY1;
        DEAC_C_KEY1:   state_reg <= DEAC_C_GAP1;    // [R13] [R15]
        DEAC_C_GAP1:   state_reg <= DEAC_C_KEY2;    // [R14]
        DEAC_C_KEY2:   state_reg <= DEAC_C_GAP2;    // [R13]
        DEAC_C_GAP2:   state_reg <= DEAC_C_STROBE;  // [R14]
        DEAC_C_STROBE: state_reg <= DEAC_C_WAIT;
        DEAC_C_WAIT: begin
          if (bus.done_flag) begin
            state_reg <= DEAC_C_CLOSE;              // [R21]
          end
        end
        DEAC_C_CLOSE: begin
          wr_done   <= 1'b1;
          state_reg <= DEAC_C_IDLE;                 // [R19]
        end
        default: state_reg <= DEAC_C_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Bus drive
  // --------------------------------------------------------------------------
  // Each other state writes one register; the gap, wait, idle and read-back states
  // write nothing, which keeps the key spacing exact.
  always_comb begin
    bus.wr_en    = 1'b1;
    bus.rd_en    = 1'b0;
    bus.sel      = `DEAC_SEL_CTRL;
    bus.wdata    = 8'h00;
    bus.done_clr = 1'b0;
    case (state_reg)
      DEAC_C_RADDR, DEAC_C_WADDR: begin
        bus.sel   = `DEAC_SEL_ADDR;
        bus.wdata = addr_reg;
      end
      DEAC_C_RSTRB:  bus.wdata = 8'h01;
      DEAC_C_RGET: begin
        bus.wr_en = 1'b0;
        bus.rd_en = 1'b1;
        bus.sel   = `DEAC_SEL_DATA;
      end
      DEAC_C_WDATA: begin
        bus.sel   = `DEAC_SEL_DATA;
        bus.wdata = data_reg;
      end
      DEAC_C_PERMIT: bus.wdata = 8'h04;
      DEAC_C_KEY1: begin
        bus.sel   = `DEAC_SEL_KEY;
        bus.wdata = `DEAC_KEY_FIRST;
      end
      DEAC_C_KEY2: begin
        bus.sel   = `DEAC_SEL_KEY;
        bus.wdata = `DEAC_KEY_SECOND;
      end
      DEAC_C_STROBE: bus.wdata = 8'h06;
      DEAC_C_CLOSE:  bus.done_clr = 1'b1;
      default:       bus.wr_en = 1'b0;
    endcase
  end

endmodule

/* File: testbench/deac_checker.sv */
// Assertion checker for the register link of the nonvolatile byte store.
`timescale 1ns/1ps
`include "deac_cfg.svh"
module deac_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       wr_en,
  input wire logic [1:0] sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       done_flag,
  input wire logic       done_clr,
  input wire logic       write_busy
);
  // ------------------
  // Helper state
  // ------------------
  localparam int wr_cyc = `DEAC_WRITE_CYCLES;
  logic       ctrl_wr;
  logic       permit_reg;
  logic [7:0] busy_cnt_reg;

  // Control writes are decoded once since several properties key on them.
  assign ctrl_wr = wr_en && (sel == `DEAC_SEL_CTRL);

  // Mirror of the permit bit as the core last wrote it.
  always_ff @(posedge clk) begin
    if (reset) begin
      permit_reg <= 1'b0;
    end else if (ctrl_wr) begin
      permit_reg <= wdata[`DEAC_CTRL_PERMIT_BIT];
    end
  end

  // Busy length is counted here; a repetition of that length would not unroll.
  always_ff @(posedge clk) begin
    if (reset || !write_busy) begin
      busy_cnt_reg <= 8'h00;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 8'h01;
    end
  end

  // ------------------
  // Properties
  // ------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_key(k);
    wr_en && sel == `DEAC_SEL_KEY && wdata == k;
  endsequence
  sequence s_unlock;
    s_key(`DEAC_KEY_FIRST) ##1 !wr_en ##1 s_key(`DEAC_KEY_SECOND) ##1 !wr_en
      ##1 ctrl_wr && wdata[`DEAC_CTRL_WR_BIT];
  endsequence

  property p_start;
    s_unlock ##0 (permit_reg && !write_busy) |=> write_busy;
  endproperty
  property p_spacing;
    s_key(`DEAC_KEY_FIRST) ##1 s_key(`DEAC_KEY_SECOND) ##1 !wr_en ##1 ctrl_wr && !write_busy
      |=> !write_busy;
  endproperty
  property p_no_permit;
    ctrl_wr && !permit_reg && !write_busy |=> !write_busy;
  endproperty
  property p_busy_len;
    $fell(write_busy) |-> $past(busy_cnt_reg) == wr_cyc - 1;
  endproperty
  property p_busy_reads;
    write_busy && sel == `DEAC_SEL_CTRL |-> rdata[`DEAC_CTRL_WR_BIT];
  endproperty
  property p_done_rise;
    $fell(write_busy) |-> ##[0:1] done_flag;
  endproperty
  property p_done_stick;
    done_flag && !done_clr |=> done_flag;
  endproperty
  property p_permit;
    sel == `DEAC_SEL_CTRL |-> rdata[`DEAC_CTRL_PERMIT_BIT] == permit_reg;
  endproperty
  property p_data_load;
    wr_en && sel == `DEAC_SEL_DATA && !write_busy ##1 !wr_en && sel == `DEAC_SEL_DATA
      |-> rdata == $past(wdata);
  endproperty
  property p_hold;
    !wr_en && sel == `DEAC_SEL_DATA && !write_busy ##1 !wr_en && sel == `DEAC_SEL_DATA
      |-> $stable(rdata);
  endproperty

  a_start: assert property (p_start)
    else $error("write did not start after a correct unlock");
  a_spacing: assert property (p_spacing)
    else $error("write started with wrong key spacing");
  a_no_permit: assert property (p_no_permit)
    else $error("write started without permit");
  a_busy_len: assert property (p_busy_len)
    else $error("write time differs from the internal timer");
  a_busy_reads: assert property (p_busy_reads)
    else $error("strobe bit reads zero during a write");
  a_done_rise: assert property (p_done_rise)
    else $error("done flag missing after write end");
  a_done_stick: assert property (p_done_stick)
    else $error("done flag dropped without a clear");
  a_permit: assert property (p_permit)
    else $error("permit bit moved without a core write");
  a_data_load: assert property (p_data_load)
    else $error("data register did not take the written byte");
  a_hold: assert property (p_hold)
    else $error("data register changed without a read or write");
endmodule

/* File: testbench/data_eeprom_access_ctrl_tb_top.sv */
// Self-checking bench: a bench-driven store plus a core-and-store pair.
`timescale 1ns/1ps
`include "deac_cfg.svh"
module data_eeprom_access_ctrl_tb_top;
  logic       clk;
  logic       reset;
  logic       clk_en;
  logic       code_protect;
  logic       prog_rd;
  logic [7:0] prog_addr;
  logic [7:0] prog_rdata;
  logic       write_busy;
  logic       req_read;
  logic       req_write;
  logic [7:0] req_addr;
  logic [7:0] req_data;
  logic       req_ready;
  logic       rd_valid;
  logic [7:0] core_rd_data;
  logic       core_wr_done;
  int         num_errors = 0;
  int         n_tests = 0;
  int         cycles = 0;

  deac_if bus_if ();
  deac_if core_if ();

  // ------------------
  // Design and checker
  // ------------------
  deac_store deac_store_inst (
    .clk, .reset, .clk_en, .bus(bus_if), .code_protect, .prog_rd, .prog_addr,
    .prog_rdata, .write_busy
  );
  // The core end drives its own store, so its sequences run free of bench traffic.
  if (1) begin : core_side
    deac_store deac_store_inst (
      .clk, .reset, .clk_en, .bus(core_if), .code_protect, .prog_rd, .prog_addr,
      .prog_rdata(), .write_busy()
    );
    deac_core deac_core_inst (
      .clk, .reset, .clk_en, .bus(core_if), .req_read, .req_write, .req_addr,
      .req_data, .req_ready, .rd_data(core_rd_data), .rd_valid, .wr_done(core_wr_done)
    );
  end
  deac_checker deac_checker_inst (
    .clk, .reset, .wr_en(bus_if.wr_en), .sel(bus_if.sel), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .done_flag(bus_if.done_flag), .done_clr(bus_if.done_clr),
    .write_busy
  );

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The whole run needs under a thousand cycles, so this only trips on a hang.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ------------------
  // Tasks
  // ------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus writes leave the strobe high so back-to-back writes never toggle it.
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    bus_if.wr_en <= 1'b1;
    bus_if.rd_en <= 1'b0;
    bus_if.sel <= s;
    bus_if.wdata <= d;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    bus_if.wr_en <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] v);
    bus_if.wr_en <= 1'b0;
    bus_if.rd_en <= 1'b1;
    bus_if.sel <= s;
    @(posedge clk);
    v = bus_if.rdata;
  endtask
  task automatic unlock(input int gap, input logic [7:0] k1, input logic [7:0] k2);
    wr(`DEAC_SEL_KEY, k1);
    if (gap > 1) idle(gap - 1);
    wr(`DEAC_SEL_KEY, k2);
    idle(1);
    wr(`DEAC_SEL_CTRL, 8'h06);
    idle(1);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    for (int s = 0; s < 3; s++) begin
      rd(2'(s), v);
      chk(v, 8'h00);
    end
    // A write presented while the enable is low must leave no trace.
    clk_en <= 1'b0;
    wr(`DEAC_SEL_ADDR, 8'h77);
    clk_en <= 1'b1;
    rd(`DEAC_SEL_ADDR, v);
    chk(v, 8'h00);
  endtask
  // Full write; with mid set, a strobe that clears permit lands mid-write.
  task automatic t_write(input logic [7:0] a, input logic [7:0] d, input logic mid);
    int n;
    logic [7:0] v;
    n = 0;
    wr(`DEAC_SEL_ADDR, a);
    wr(`DEAC_SEL_DATA, d);
    wr(`DEAC_SEL_CTRL, 8'h04);
    unlock(2, `DEAC_KEY_FIRST, `DEAC_KEY_SECOND);
    bus_if.sel <= `DEAC_SEL_CTRL;
    @(posedge clk);
    chk({7'h0, bus_if.rdata[1]}, 8'h01);
    // Outputs are read right at the edge, so each sample is the settled value
    // of the cycle that this edge closes.
    while (write_busy === 1'b1 && n < 300) begin
      n++;
      bus_if.wr_en <= (mid && n == 20);
      bus_if.wdata <= 8'h02;
      @(posedge clk);
    end
    chk(8'(n), 8'(`DEAC_WRITE_CYCLES - 1));
    chk({7'h0, bus_if.done_flag}, 8'h01);
    chk(bus_if.rdata & 8'h06, mid ? 8'h00 : 8'h04);
    repeat (3) @(posedge clk);
    chk({7'h0, bus_if.done_flag}, 8'h01);
    bus_if.done_clr <= 1'b1;
    @(posedge clk);
    bus_if.done_clr <= 1'b0;
    @(posedge clk);
    chk({7'h0, bus_if.done_flag}, 8'h00);
    wr(`DEAC_SEL_ADDR, a);
    rd(`DEAC_SEL_ADDR, v);
    chk(v, a);
    wr(`DEAC_SEL_CTRL, 8'h01);
    rd(`DEAC_SEL_DATA, v);
    chk(v, d);
    wr(`DEAC_SEL_DATA, ~d);
    rd(`DEAC_SEL_DATA, v);
    chk(v, ~d);
    rd(`DEAC_SEL_DATA, v);
    chk(v, ~d);
  endtask
  task automatic t_prog(input logic [7:0] a, input logic [7:0] d);
    for (int p = 0; p < 2; p++) begin
      code_protect <= (p == 1);
      prog_addr <= a;
      prog_rd <= 1'b1;
      @(posedge clk);
      prog_rd <= 1'b0;
      @(posedge clk);
      chk(prog_rdata, (p == 1) ? 8'h00 : d);
    end
  endtask
  // No permit, keys back to back, keys swapped: each must leave the byte intact.
  // Protection is still on here, so the core reads are checked under it.
  task automatic t_refuse(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    for (int m = 0; m < 3; m++) begin
      wr(`DEAC_SEL_ADDR, a);
      wr(`DEAC_SEL_DATA, ~d);
      wr(`DEAC_SEL_CTRL, (m == 0) ? 8'h00 : 8'h04);
      if (m == 2) unlock(2, `DEAC_KEY_SECOND, `DEAC_KEY_FIRST);
      else unlock(2 - m, `DEAC_KEY_FIRST, `DEAC_KEY_SECOND);
      rd(`DEAC_SEL_CTRL, v);
      chk({7'h0, write_busy}, 8'h00);
      chk(v & 8'h0F, 8'h0C);
      wr(`DEAC_SEL_CTRL, 8'h01);
      rd(`DEAC_SEL_DATA, v);
      chk(v, d);
    end
  endtask
  // The core end runs a whole unlocked write on its own store, then reads back.
  task automatic t_core();
    int n;
    n = 0;
    chk({7'h0, req_ready}, 8'h01);
    req_addr  <= 8'h33;
    req_data  <= 8'hC3;
    req_write <= 1'b1;
    @(posedge clk);
    req_write <= 1'b0;
    while (core_wr_done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, core_wr_done}, 8'h01);
    req_read <= 1'b1;
    @(posedge clk);
    req_read <= 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk({7'h0, rd_valid}, 8'h01);
    chk(core_rd_data, 8'hC3);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    code_protect = 1'b0;
    prog_rd = 1'b0;
    prog_addr = 8'h00;
    req_read = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_data = 8'h00;
    bus_if.wr_en = 1'b0;
    bus_if.rd_en = 1'b0;
    bus_if.sel = 2'h0;
    bus_if.wdata = 8'h00;
    bus_if.done_clr = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_write(8'h00, 8'hA5, 1'b0);
    t_write(8'hFF, 8'h5A, 1'b1);
    t_prog(8'hFF, 8'h5A);
    t_refuse(8'hFF, 8'h5A);
    t_core();
    report_and_stop();
  end
endmodule
